// ===== hdl/memmap_regs.svh
/*
 * address map constants for the system memory map decoder: range limits,
 * master-side offsets, external chip-select windows and the master id
 * that may reach external memory.
 * assumes byte addresses, 24-bit processor space and 32-bit dma/usb space.
 */
// Behaviour
// RULE1: cpu 00c0-ffff decodes to dual-port ram
// RULE2: dual-port block takes two accesses, no stall
// RULE3: dma dual-port address minus fixed offset
// RULE4: lowest 192 bytes are core registers
// RULE5: cpu 010000-03ffff decodes to single-port ram
// RULE6: single-port block takes one access per cycle
// RULE7: same single-port block clash stalls one access
// RULE8: dma/usb single-port address minus fixed offset
// RULE9: cpu fe0000-ffffff decodes to four rom blocks
// RULE10: only processor buses reach the rom
// RULE11: rom disable bit set leaves rom unmapped
// RULE12: hardware reset clears rom disable bit
// RULE13: software reset leaves rom disable bit
// RULE14: only dma controller three reaches external
// RULE15: usb never reaches dual-port ram
// RULE16: cpu 050000-ffffff decodes to five external spaces
// RULE17: sync space selects a, or a plus b
// RULE18: one async select per space, during access
// RULE19: rom range taken from last async space
// RULE20: separate select decode for each space
// RULE21: software sets up external port before use
// RULE22: unmapped ranges select nothing, no selects
`ifndef MEMMAP_REGS_SVH
`define MEMMAP_REGS_SVH

// processor byte address ranges
`define MMR_HI 32'h0000_00bf
`define DPRAM_LO 32'h0000_00c0
`define DPRAM_HI 32'h0000_ffff
`define SPRAM_LO 32'h0001_0000
`define SPRAM_HI 32'h0003_ffff
`define EXT_LO 32'h0005_0000
`define CS2_LO 32'h0080_0000
`define CS3_LO 32'h00c0_0000
`define CS4_LO 32'h00e0_0000
`define CS5_LO 32'h00f0_0000
`define ROM_LO 32'h00fe_0000
`define ROM_HI 32'h00ff_ffff
`define SPRAM_FIRST_BLK 5'h08

// dma/usb side windows
`define DMA_DP_OFS 32'h0001_0000
`define DMA_DP_LO 32'h0001_0000
`define DMA_DP_HI 32'h0001_ffff
`define DMA_SP_OFS 32'h0008_0000
`define DMA_SP_LO 32'h0009_0000
`define DMA_SP_HI 32'h000b_ffff
`define DMA_CS0_BASE 32'h0100_0000
`define DMA_CS2_BASE 32'h0200_0000
`define DMA_CS3_BASE 32'h0300_0000
`define DMA_CS4_BASE 32'h0400_0000
`define DMA_CS5_BASE 32'h0500_0000
`define CS0_SIZE 32'h007b_0000
`define CS2_SIZE 32'h0040_0000
`define CS3_SIZE 32'h0020_0000
`define CS4_SIZE 32'h0010_0000
`define CS5_SIZE 32'h000e_0000
`define EXT_DMA_ID 2'h3

`endif

// ===== hdl/memmap_pkg.sv
/*
 * types shared by the memory map decoder files: master kinds and targets.
 * assumes nothing beyond a systemverilog compiler.
 */
package memmap_pkg;
    // =====================================================
    // master that presents an access
    typedef enum logic [3:0] {
        SRC_CPU_PROG = 4'b0001,
        SRC_CPU_DATA = 4'b0010,
        SRC_DMA = 4'b0100,
        SRC_USB = 4'b1000
    } src_type;
    // =====================================================
    // memory target picked by the decode
    typedef enum logic [5:0] {
        TGT_NONE = 6'b000001,
        TGT_MMR = 6'b000010,
        TGT_DPRAM = 6'b000100,
        TGT_SPRAM = 6'b001000,
        TGT_ROM = 6'b010000,
        TGT_EXT = 6'b100000
    } tgt_type;
endpackage

// ===== hdl/addr_decode.sv
/*
 * combinational decode of one master's address into target, block,
 * processor byte address and external space (one-hot: sync, cs2..cs5).
 * assumes the caller registers the results.
 */
`timescale 1ns/1ps
`include "memmap_regs.svh"
module addr_decode (
    input wire memmap_pkg::src_type src,
    input wire [1:0] dma_id,
    input wire [31:0] addr,
    input wire rom_dis,
    output memmap_pkg::tgt_type tgt,
    output logic [4:0] blk,
    output logic [23:0] cpu_a,
    output logic [4:0] space
);
    import memmap_pkg::*;

    // =====================================================
    // helpers
    function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic seg_hit(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] size);
        return (a >= base) && (a < base + size);
    endfunction

    logic is_cpu; // processor program or data bus
    logic mapped; // address lands somewhere in processor view
    logic [31:0] eff; // processor-view byte address

    // =====================================================
    // translate to processor view, then decode
    always_comb begin
        is_cpu = (src == SRC_CPU_PROG) || (src == SRC_CPU_DATA);
        mapped = 1'b1;
        eff = 32'h0000_0000;
        tgt = TGT_NONE;
        space = 5'h00;
        blk = 5'h00;
        if (is_cpu) begin
            eff = {8'h00, addr[23:0]};
        end else if (in_rng(addr, `DMA_DP_LO, `DMA_DP_HI)) begin
            eff = addr - `DMA_DP_OFS; // [RULE3]
        end else if (in_rng(addr, `DMA_SP_LO, `DMA_SP_HI)) begin
            eff = addr - `DMA_SP_OFS; // [RULE8]
        end else if (seg_hit(addr, `DMA_CS0_BASE, `CS0_SIZE)) begin
            eff = `EXT_LO + (addr - `DMA_CS0_BASE);
        end else if (seg_hit(addr, `DMA_CS2_BASE, `CS2_SIZE)) begin
            eff = `CS2_LO + (addr - `DMA_CS2_BASE);
        end else if (seg_hit(addr, `DMA_CS3_BASE, `CS3_SIZE)) begin
            eff = `CS3_LO + (addr - `DMA_CS3_BASE);
        end else if (seg_hit(addr, `DMA_CS4_BASE, `CS4_SIZE)) begin
            eff = `CS4_LO + (addr - `DMA_CS4_BASE);
        end else if (seg_hit(addr, `DMA_CS5_BASE, `CS5_SIZE)) begin
            eff = `CS5_LO + (addr - `DMA_CS5_BASE);
        end else begin
            mapped = 1'b0; // includes the dma view of the rom window
        end
        cpu_a = eff[23:0];
        if (!mapped) begin
            tgt = TGT_NONE; // [RULE22]
        end else if (eff <= `MMR_HI) begin
            // core registers sit below the first ram block
            tgt = is_cpu ? TGT_MMR : TGT_NONE; // [RULE4]
        end else if (in_rng(eff, `DPRAM_LO, `DPRAM_HI)) begin
            if (src != SRC_USB) begin // [RULE15]
                tgt = TGT_DPRAM; // [RULE1]
                blk = {2'b00, eff[15:13]};
            end
        end else if (in_rng(eff, `SPRAM_LO, `SPRAM_HI)) begin
            tgt = TGT_SPRAM; // [RULE5]
            blk = eff[17:13] - `SPRAM_FIRST_BLK;
        end else if (in_rng(eff, `ROM_LO, `ROM_HI)) begin
            // rom window is rom or nothing; never handed to cs5
            if (is_cpu && !rom_dis) begin // [RULE10] [RULE11] [RULE19]
                tgt = TGT_ROM; // [RULE9]
                blk = {3'b000, eff[16:15]};
            end
        end else if (in_rng(eff, `EXT_LO, `ROM_LO - 32'h1)) begin
            if (is_cpu || (src == SRC_DMA && dma_id == `EXT_DMA_ID)) begin // [RULE14]
                tgt = TGT_EXT; // [RULE16]
                if (eff < `CS2_LO) begin
                    space = 5'b00001; // [RULE20]
                end else if (eff < `CS3_LO) begin
                    space = 5'b00010;
                end else if (eff < `CS4_LO) begin
                    space = 5'b00100;
                end else if (eff < `CS5_LO) begin
                    space = 5'b01000;
                end else begin
                    space = 5'b10000;
                end
            end
        end
    end
endmodule

// ===== hdl/memmap_router.sv
/*
 * system memory map router: decodes two accesses per cycle (port a, the
 * higher priority, and port b), resolves block clashes, holds the rom
 * disable bit and drives the external chip selects (active low).
 * assumes masters repeat a request that was answered with b_stall_r.
 */
`timescale 1ns/1ps
`include "memmap_regs.svh"
module memmap_router (
    input wire ref_clk,
    input wire srst,
    input wire ce,
    input wire a_req,
    input wire memmap_pkg::src_type a_src,
    input wire [1:0] a_dma_id,
    input wire [31:0] a_addr,
    input wire a_write,
    input wire b_req,
    input wire memmap_pkg::src_type b_src,
    input wire [1:0] b_dma_id,
    input wire [31:0] b_addr,
    input wire b_write,
    input wire rom_disable_set,
    input wire rom_disable_clr,
    input wire sync_pair_mode,
    output memmap_pkg::tgt_type a_target_r,
    output logic [4:0] a_block_r,
    output logic [23:0] a_addr_r,
    output logic a_write_r,
    output logic a_grant_r,
    output memmap_pkg::tgt_type b_target_r,
    output logic [4:0] b_block_r,
    output logic [23:0] b_addr_r,
    output logic b_write_r,
    output logic b_grant_r,
    output logic b_stall_r,
    output logic rom_disable_bit,
    output logic sync_space_select_a_n,
    output logic sync_space_select_b_n,
    output logic [3:0] async_space_selects_n
);
    import memmap_pkg::*;

    // =====================================================
    // decode results, combinational
    tgt_type a_tgt; // port a target
    tgt_type b_tgt; // port b target
    logic [4:0] a_blk; // port a block
    logic [4:0] b_blk; // port b block
    logic [23:0] a_cpu; // port a processor address
    logic [23:0] b_cpu; // port b processor address
    logic [4:0] a_space; // port a external space
    logic [4:0] b_space; // port b external space
    logic a_hit; // port a valid and mapped
    logic b_hit; // port b valid and mapped
    logic clash; // port b must wait
    logic [4:0] ext_space_nxt; // space driven next cycle
    logic rom_dis_nxt; // next rom disable value

    addr_decode dec_a (
        .src(a_src),
        .dma_id(a_dma_id),
        .addr(a_addr),
        .rom_dis(rom_disable_bit),
        .tgt(a_tgt),
        .blk(a_blk),
        .cpu_a(a_cpu),
        .space(a_space)
    );

    addr_decode dec_b (
        .src(b_src),
        .dma_id(b_dma_id),
        .addr(b_addr),
        .rom_dis(rom_disable_bit),
        .tgt(b_tgt),
        .blk(b_blk),
        .cpu_a(b_cpu),
        .space(b_space)
    );

    // =====================================================
    // clash resolution
    // only memories with a single access path need arbitration
    function automatic logic single_path(input tgt_type t);
        return (t == TGT_SPRAM) || (t == TGT_ROM) || (t == TGT_EXT);
    endfunction

    always_comb begin
        a_hit = a_req && (a_tgt != TGT_NONE);
        b_hit = b_req && (b_tgt != TGT_NONE);
        clash = 1'b0;
        if (a_hit && b_hit && a_tgt == b_tgt && single_path(a_tgt)) begin
            // external port serves one access at a time, any space
            if (a_tgt == TGT_EXT) begin
                clash = 1'b1;
            end else if (a_blk == b_blk) begin
                clash = 1'b1; // [RULE6] [RULE7]
            end
        end
        // dual-port blocks never clash, both ports go through [RULE2]
        ext_space_nxt = 5'h00;
        if (a_hit && a_tgt == TGT_EXT) begin
            ext_space_nxt = a_space;
        end else if (b_hit && b_tgt == TGT_EXT) begin
            ext_space_nxt = b_space;
        end
    end

    // =====================================================
    // rom disable bit
    // set beats clear if software writes both in one cycle; of the resets only
    // srst clears it, the software reset instruction has no path here
    always_comb begin
        rom_dis_nxt = rom_disable_bit;
        if (rom_disable_set) begin
            rom_dis_nxt = 1'b1;
        end else if (rom_disable_clr) begin
            rom_dis_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rom_disable_bit <= 1'b0; // [RULE12]
        end else if (ce) begin
            rom_disable_bit <= rom_dis_nxt; // [RULE13]
        end
    end

    // =====================================================
    // port a answer, never stalled
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            a_target_r <= TGT_NONE;
            a_block_r <= 5'h00;
            a_addr_r <= 24'h000000;
            a_write_r <= 1'b0;
            a_grant_r <= 1'b0;
        end else if (ce) begin
            a_target_r <= a_req ? a_tgt : TGT_NONE;
            a_block_r <= a_blk;
            a_addr_r <= a_cpu;
            a_write_r <= a_req && a_write;
            a_grant_r <= a_hit;
        end
    end

    // =====================================================
    // port b answer, stalled for one cycle on a clash
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            b_target_r <= TGT_NONE;
            b_block_r <= 5'h00;
            b_addr_r <= 24'h000000;
            b_write_r <= 1'b0;
            b_grant_r <= 1'b0;
            b_stall_r <= 1'b0;
        end else if (ce) begin
            b_target_r <= b_req ? b_tgt : TGT_NONE;
            b_block_r <= b_blk;
            b_addr_r <= b_cpu;
            b_write_r <= b_req && b_write && !clash;
            b_grant_r <= b_hit && !clash; // [RULE7]
            b_stall_r <= clash; // [RULE7]
        end
    end

    // =====================================================
    // chip selects, low only in the cycle after a granted access
    // software must have set up the external port first; nothing
    // here can tell whether it did
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync_space_select_a_n <= 1'b1;
            sync_space_select_b_n <= 1'b1;
            async_space_selects_n <= 4'hf;
        end else if (ce) begin
            sync_space_select_a_n <= !ext_space_nxt[0]; // [RULE17]
            sync_space_select_b_n <= !(ext_space_nxt[0] && sync_pair_mode); // [RULE17]
            async_space_selects_n <= ~ext_space_nxt[4:1]; // [RULE18] [RULE20] [RULE22]
        end
    end

    // =====================================================
    // assertions
    // judged on the registered answer, so a wrong bit timing in the
    // decode path shows up here as well
    rom_hidden_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && a_req && rom_disable_bit |=> a_target_r != TGT_ROM) // [RULE11]
        else $error("rom decoded while disabled");

    rom_reset_a: assert property (@(posedge ref_clk) disable iff (srst)
        $past(srst) |-> !rom_disable_bit) // [RULE12]
        else $error("rom disable bit not cleared by reset");

    usb_no_dp_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && b_req && b_src == SRC_USB |=> b_target_r != TGT_DPRAM) // [RULE15]
        else $error("usb routed to dual-port ram");

    dma_ext_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && b_req && b_src == SRC_DMA && b_dma_id != `EXT_DMA_ID
        |=> b_target_r != TGT_EXT) // [RULE14]
        else $error("dma 0-2 routed to external space");

    dma_no_rom_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && b_req && (b_src == SRC_DMA || b_src == SRC_USB)
        |=> b_target_r != TGT_ROM) // [RULE10]
        else $error("dma or usb routed to rom");

    sp_clash_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && a_req && b_req && a_tgt == TGT_SPRAM && b_tgt == TGT_SPRAM
        && a_blk == b_blk |=> a_grant_r && b_stall_r && !b_grant_r) // [RULE7]
        else $error("single-port clash not stalled");

    dp_both_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && a_req && b_req && a_tgt == TGT_DPRAM && b_tgt == TGT_DPRAM
        |=> a_grant_r && b_grant_r && !b_stall_r) // [RULE2]
        else $error("dual-port access stalled");

    dma_dp_xlat_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && b_req && b_src == SRC_DMA && b_addr == 32'h0001_2000
        |=> b_target_r == TGT_DPRAM && b_addr_r == 24'h002000 && b_block_r == 5'h01) // [RULE3]
        else $error("dma dual-port offset wrong");

    dma_sp_xlat_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && b_req && b_src == SRC_DMA && b_addr == 32'h0009_0000
        |=> b_target_r == TGT_SPRAM && b_addr_r == 24'h010000 && b_block_r == 5'h00) // [RULE8]
        else $error("dma single-port offset wrong");

    mmr_low_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && a_req && a_src == SRC_CPU_DATA && a_addr == 32'h0000_00bf
        |=> a_target_r == TGT_MMR ##0 $past(a_tgt) != TGT_DPRAM) // [RULE4]
        else $error("register window decoded as ram");

    async_sel_a: assert property (@(posedge ref_clk) disable iff (srst)
        async_space_selects_n != 4'hf |-> $onehot(~async_space_selects_n)
        && sync_space_select_a_n && ((a_grant_r && a_target_r == TGT_EXT)
        || (b_grant_r && b_target_r == TGT_EXT))) // [RULE18]
        else $error("async select without external access");

    pair_sel_a: assert property (@(posedge ref_clk) disable iff (srst)
        !sync_space_select_b_n |-> !sync_space_select_a_n) // [RULE17]
        else $error("second sync select without first");

    // =====================================================
    // covers
    sp_clash_c: cover property (@(posedge ref_clk) disable iff (srst)
        b_stall_r && a_target_r == TGT_SPRAM);
    dp_dual_c: cover property (@(posedge ref_clk) disable iff (srst)
        a_grant_r && b_grant_r && a_target_r == TGT_DPRAM && b_target_r == TGT_DPRAM);
    rom_off_c: cover property (@(posedge ref_clk) disable iff (srst)
        rom_disable_bit && a_req && a_addr == 32'h00fe_0000 ##1 !a_grant_r);
    cs5_c: cover property (@(posedge ref_clk) disable iff (srst)
        !async_space_selects_n[3]);
endmodule

// ===== tb/port_b_master.sv
/*
 * port b master model: presents the bench's accesses on port b and
 * repeats any access that the router answers with a stall.
 * assumes one clock, srst synchronous and active high.
 */
`timescale 1ns/1ps
module port_b_master (
    input wire ref_clk,
    input wire srst,
    input wire cmd_req,
    input wire memmap_pkg::src_type cmd_src,
    input wire [1:0] cmd_dma_id,
    input wire [31:0] cmd_addr,
    input wire cmd_write,
    input wire b_stall_r,
    output logic b_req,
    output memmap_pkg::src_type b_src,
    output logic [1:0] b_dma_id,
    output logic [31:0] b_addr,
    output logic b_write
);
    import memmap_pkg::*;
    // ==========================================
    // presented access, packed {req, src, id, addr, write}
    logic [39:0] last_r; // last access on the port, kept for a retry
    logic [39:0] pres; // what the port shows this cycle
    // ==========================================
    // choose retry, new command or an idle port
    always_comb begin
        if (b_stall_r) begin
            pres = last_r; // refused access is repeated whole
        end else if (cmd_req) begin
            pres = {1'b1, cmd_src, cmd_dma_id, cmd_addr, cmd_write};
        end else begin
            // idle address toggles so a stale value never looks valid
            pres = {1'b0, SRC_CPU_DATA, 2'h0, ~last_r[32:1], 1'b0};
        end
    end
    // remember each presented access
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            last_r <= 40'h0;
        end else begin
            last_r <= pres;
        end
    end
    assign b_req = pres[39];
    assign b_src = src_type'(pres[38:35]);
    assign b_dma_id = pres[34:33];
    assign b_addr = pres[32:1];
    assign b_write = pres[0];
endmodule

// ===== tb/tb.sv
/*
 * self-checking bench for memmap_router: cpu and dma/usb decode, clashes,
 * rom disable bit and chip selects. port b goes through port_b_master.
 * assumes a 40 MHz clock and the router's one-cycle registered answer.
 */
`timescale 1ns/1ps
module tb;
    import memmap_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic a_req = 1'b0;
    src_type a_src = SRC_CPU_DATA;
    logic [1:0] a_dma_id = 2'h0;
    logic [31:0] a_addr = 32'h0;
    logic a_write = 1'b0;
    logic cmd_req = 1'b0;
    src_type cmd_src = SRC_CPU_DATA;
    logic [1:0] cmd_dma_id = 2'h0;
    logic [31:0] cmd_addr = 32'h0;
    logic set_r = 1'b0;
    logic clr_r = 1'b0;
    logic pair = 1'b0; // set once, after the single-select external cases
    logic ce = 1'b1; // clock enable, dropped in one scenario
    logic b_req, b_write, b_write_r, b_grant_r, b_stall_r, a_write_r, a_grant_r;
    src_type b_src;
    logic [1:0] b_dma_id;
    logic [31:0] b_addr;
    tgt_type a_target_r, b_target_r;
    logic [4:0] a_block_r, b_block_r;
    logic [23:0] a_addr_r, b_addr_r;
    logic rom_bit, sel_a_n, sel_b_n;
    logic [3:0] async_n;
    int err_count = 0;
    int checks_done = 0;
    always #12.5 ref_clk = ~ref_clk;
    // ==========================================
    // design and port b master model
    memmap_router dut (.ref_clk(ref_clk), .srst(srst), .ce(ce), .a_req(a_req),
        .a_src(a_src), .a_dma_id(a_dma_id), .a_addr(a_addr), .a_write(a_write),
        .b_req(b_req), .b_src(b_src), .b_dma_id(b_dma_id), .b_addr(b_addr),
        .b_write(b_write), .rom_disable_set(set_r), .rom_disable_clr(clr_r),
        .sync_pair_mode(pair), .a_target_r(a_target_r), .a_block_r(a_block_r),
        .a_addr_r(a_addr_r), .a_write_r(a_write_r), .a_grant_r(a_grant_r),
        .b_target_r(b_target_r), .b_block_r(b_block_r), .b_addr_r(b_addr_r),
        .b_write_r(b_write_r), .b_grant_r(b_grant_r), .b_stall_r(b_stall_r),
        .rom_disable_bit(rom_bit), .sync_space_select_a_n(sel_a_n),
        .sync_space_select_b_n(sel_b_n), .async_space_selects_n(async_n));
    port_b_master pb (.ref_clk(ref_clk), .srst(srst), .cmd_req(cmd_req),
        .cmd_src(cmd_src), .cmd_dma_id(cmd_dma_id), .cmd_addr(cmd_addr),
        .cmd_write(1'b1), .b_stall_r(b_stall_r), .b_req(b_req), .b_src(b_src),
        .b_dma_id(b_dma_id), .b_addr(b_addr), .b_write(b_write));
    // ==========================================
    // compare tasks
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_tgt(input tgt_type got, input tgt_type exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t target %b expected %b", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios
    // one port a access, judged after the answering edge; sl = {cs0,cs1,cs2..cs5}
    task automatic a_case(input src_type s, input logic [1:0] id, input logic [31:0] ad,
        input tgt_type t, input logic [4:0] bk, input logic [23:0] ca, input logic [5:0] sl);
        @(posedge ref_clk);
        a_req <= 1'b1;
        a_src <= s;
        a_dma_id <= id;
        a_addr <= ad;
        a_write <= 1'b1;
        @(posedge ref_clk);
        a_req <= 1'b0;
        #1;
        chk_tgt(a_target_r, t);
        chk_val(a_grant_r, t != TGT_NONE);
        chk_val(a_write_r, 1'b1);
        chk_val({sel_a_n, sel_b_n, async_n[0], async_n[1], async_n[2], async_n[3]}, sl);
        if (t != TGT_NONE) begin
            chk_val(a_block_r, bk);
            chk_val(a_addr_r, ca);
        end
    endtask
    // two accesses in one cycle; b may be stalled and then retried
    task automatic pair_case(input logic [31:0] aa, input logic [31:0] ba,
        input src_type bs, input tgt_type t, input logic [4:0] bk, input logic stall);
        @(posedge ref_clk);
        a_req <= 1'b1;
        a_src <= SRC_CPU_DATA;
        a_addr <= aa;
        cmd_req <= 1'b1;
        cmd_src <= bs;
        cmd_addr <= ba;
        @(posedge ref_clk);
        a_req <= 1'b0;
        cmd_req <= 1'b0;
        #1;
        chk_val(a_grant_r, 1'b1);
        chk_tgt(b_target_r, t);
        chk_val(b_stall_r, stall);
        chk_val(b_grant_r, !stall && t != TGT_NONE);
        chk_val(b_write_r, !stall);
        if (stall) begin
            @(posedge ref_clk);
            #1;
            chk_val(b_grant_r, 1'b1);
            chk_val(b_stall_r, 1'b0);
            chk_tgt(a_target_r, TGT_NONE);
        end
        chk_val(b_addr_r, aa[23:0]);
        chk_val(b_block_r, bk);
    endtask
    // a request and a set pulse while ce is low must change no flop
    task automatic ce_case();
        @(posedge ref_clk);
        ce <= 1'b0;
        a_req <= 1'b1;
        a_src <= SRC_CPU_DATA;
        a_addr <= 32'h0005_0000;
        set_r <= 1'b1;
        @(posedge ref_clk);
        ce <= 1'b1;
        a_req <= 1'b0;
        set_r <= 1'b0;
        #1;
        chk_tgt(a_target_r, TGT_NONE);
        chk_val({rom_bit, sel_a_n}, 2'b01);
    endtask
    // pulse set or clear of the rom disable bit and check its new level
    task automatic rom_bit_case(input logic s, input logic c, input logic exp);
        @(posedge ref_clk);
        set_r <= s;
        clr_r <= c;
        @(posedge ref_clk);
        set_r <= 1'b0;
        clr_r <= 1'b0;
        #1;
        chk_val(rom_bit, exp);
    endtask
    task automatic reset_case();
        @(posedge ref_clk);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk_val(rom_bit, 1'b0);
        chk_tgt(a_target_r, TGT_NONE);
        chk_val({sel_a_n, sel_b_n, async_n}, 6'h3f);
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        reset_case();
        ce_case();
        a_case(SRC_CPU_DATA, 2'h0, 32'h10, TGT_MMR, 5'h0, 24'h10, 6'h3f);
        a_case(SRC_CPU_DATA, 2'h0, 32'hbf, TGT_MMR, 5'h0, 24'hbf, 6'h3f);
        a_case(SRC_CPU_PROG, 2'h0, 32'hc0, TGT_DPRAM, 5'h0, 24'hc0, 6'h3f);
        a_case(SRC_CPU_DATA, 2'h0, 32'hffff, TGT_DPRAM, 5'h7, 24'hffff, 6'h3f);
        a_case(SRC_CPU_DATA, 2'h0, 32'h10000, TGT_SPRAM, 5'h0, 24'h10000, 6'h3f);
        a_case(SRC_CPU_PROG, 2'h0, 32'h3ffff, TGT_SPRAM, 5'h17, 24'h3ffff, 6'h3f);
        a_case(SRC_CPU_DATA, 2'h0, 32'h40000, TGT_NONE, 5'h0, 24'h0, 6'h3f);
        a_case(SRC_CPU_DATA, 2'h0, 32'h50000, TGT_EXT, 5'h0, 24'h50000, 6'h1f);
        a_case(SRC_CPU_DATA, 2'h0, 32'h800000, TGT_EXT, 5'h0, 24'h800000, 6'h37);
        a_case(SRC_CPU_DATA, 2'h0, 32'hc00000, TGT_EXT, 5'h0, 24'hc00000, 6'h3b);
        a_case(SRC_CPU_DATA, 2'h0, 32'he00000, TGT_EXT, 5'h0, 24'he00000, 6'h3d);
        a_case(SRC_CPU_DATA, 2'h0, 32'hfdffff, TGT_EXT, 5'h0, 24'hfdffff, 6'h3e);
        a_case(SRC_CPU_PROG, 2'h0, 32'hfe0000, TGT_ROM, 5'h0, 24'hfe0000, 6'h3f);
        a_case(SRC_CPU_DATA, 2'h0, 32'hff8000, TGT_ROM, 5'h3, 24'hff8000, 6'h3f);
        a_case(SRC_DMA, 2'h0, 32'h100c0, TGT_DPRAM, 5'h0, 24'hc0, 6'h3f);
        a_case(SRC_DMA, 2'h1, 32'h10010, TGT_NONE, 5'h0, 24'h0, 6'h3f);
        a_case(SRC_DMA, 2'h0, 32'h90000, TGT_SPRAM, 5'h0, 24'h10000, 6'h3f);
        a_case(SRC_USB, 2'h0, 32'hbffff, TGT_SPRAM, 5'h17, 24'h3ffff, 6'h3f);
        a_case(SRC_USB, 2'h0, 32'h100c0, TGT_NONE, 5'h0, 24'h0, 6'h3f);
        a_case(SRC_DMA, 2'h3, 32'h1000000, TGT_EXT, 5'h0, 24'h50000, 6'h1f);
        a_case(SRC_DMA, 2'h2, 32'h1000000, TGT_NONE, 5'h0, 24'h0, 6'h3f);
        a_case(SRC_DMA, 2'h3, 32'h50e0000, TGT_NONE, 5'h0, 24'h0, 6'h3f);
        pair_case(32'h2000, 32'h12000, SRC_DMA, TGT_DPRAM, 5'h1, 1'b0);
        pair_case(32'h10000, 32'h90000, SRC_DMA, TGT_SPRAM, 5'h0, 1'b1);
        pair_case(32'h2000, 32'h12000, SRC_USB, TGT_NONE, 5'h0, 1'b0);
        @(posedge ref_clk);
        pair <= 1'b1;
        a_case(SRC_CPU_DATA, 2'h0, 32'h50000, TGT_EXT, 5'h0, 24'h50000, 6'h0f);
        rom_bit_case(1'b1, 1'b0, 1'b1);
        a_case(SRC_CPU_DATA, 2'h0, 32'hfe0000, TGT_NONE, 5'h0, 24'h0, 6'h3f);
        rom_bit_case(1'b0, 1'b1, 1'b0);
        a_case(SRC_CPU_PROG, 2'h0, 32'hfe8000, TGT_ROM, 5'h1, 24'hfe8000, 6'h3f);
        rom_bit_case(1'b1, 1'b1, 1'b1);
        reset_case();
        final_report();
    end
    initial begin
        #50000;
        err_count++;
        final_report();
    end
endmodule
